// [logic/dgs_regs.svh]
`ifndef DGS_REGS_SVH
`define DGS_REGS_SVH

// ***********************************************
// register offsets and field positions
// ***********************************************
`define DGS_ADDR_W          5
`define DGS_GAIN_STATUS_OFS 5'h0A
`define DGS_STORED_OFS      5'h1A
`define DGS_GAIN_LSB        8
`define DGS_POR_BIT         7
`define DGS_BUSY_BIT        6
`define DGS_ADDR_MSB        6
`define DGS_ADDR_PIN_LSB    2
`define DGS_REF_SUPPLY      2'h0

// ***********************************************
// reset values
// ***********************************************
`define DGS_NV_INIT         16'h0060

// ***********************************************
// timing
// ***********************************************
`define DGS_CLK_PERIOD_NS   10
`define DGS_NV_LOAD_NS      200
`define DGS_NV_WRITE_NS     5000
`define DGS_NV_LOAD_CYC     ((`DGS_NV_LOAD_NS + `DGS_CLK_PERIOD_NS - 1) / `DGS_CLK_PERIOD_NS)
`define DGS_NV_WRITE_CYC    ((`DGS_NV_WRITE_NS + `DGS_CLK_PERIOD_NS - 1) / `DGS_CLK_PERIOD_NS)

`endif

// [logic/dgs_pkg.sv]
`include "dgs_regs.svh"

package dgs_pkg;

   // ***********************************************
   // types
   // ***********************************************
   typedef enum logic [1:0] {
      st_load,
      st_idle,
      st_nv_write
   } dgs_phase_type;

   typedef struct packed {
      dgs_phase_type phase;
      logic [15:0]   cnt;
      logic [1:0]    gain_vol;
      logic          por_flag;
      logic          nv_busy;
      logic          hv_s1;
      logic          hv_s2;
      logic [1:0]    pin_s1;
      logic [1:0]    pin_s2;
      logic          bor_s1;
      logic          bor_s2;
      logic          bor_prev;
      logic [1:0]    gain_eff;
      logic [6:0]    bus_addr;
      logic          rsp_valid;
      logic          rsp_error;
      logic [15:0]   rsp_rdata;
   } dgs_state_type;

   // ***********************************************
   // functions
   // ***********************************************
   function automatic logic [15:0] dgs_status_word(logic [1:0] gain, logic por, logic busy);
      logic [15:0] w;
      w = 16'h0000;
      w[`DGS_GAIN_LSB +: 2] = gain;
      w[`DGS_POR_BIT]       = por;
      w[`DGS_BUSY_BIT]      = busy;
      return w;
   endfunction

   function automatic logic [15:0] dgs_stored_word(logic [15:0] raw, logic [1:0] mask);
      logic [15:0] w;
      w = 16'h0000;
      w[`DGS_GAIN_LSB +: 2]  = raw[`DGS_GAIN_LSB +: 2] & mask;
      w[`DGS_ADDR_MSB:0]     = raw[`DGS_ADDR_MSB:0];
      return w;
   endfunction

endpackage

// [logic/dgs_nv_mem.sv]
`timescale 1ns/10ps
`include "dgs_regs.svh"

module dgs_nv_mem #(
   parameter int          WIDTH = 16,
   parameter int          DEPTH = 1,
   parameter int          AW    = 1,
   parameter logic [15:0] INIT  = `DGS_NV_INIT
) (
   // clock
   input  wire logic             ref_clk,
   // write side
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   // read side
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] words;
      logic [WIDTH-1:0]            rd_data;
   } dgs_mem_state_type;

   // ***********************************************
   // contents hold through reset
   // ***********************************************
   dgs_mem_state_type st = {{DEPTH{INIT[WIDTH-1:0]}}, INIT[WIDTH-1:0]};
   dgs_mem_state_type next_st;

   always_comb begin
      next_st = st;
      if (wr_en) begin
         next_st.words[wr_addr] = wr_data;
      end
      next_st.rd_data = st.words[rd_addr];
   end

   always_ff @(posedge ref_clk) begin
      st <= next_st;
   end

   assign rd_data = st.rd_data;

endmodule // dgs_nv_mem

// [logic/dgs_top.sv]
`timescale 1ns/10ps
`include "dgs_regs.svh"

module dgs_top
   import dgs_pkg::*;
#(
   parameter int NUM_CH       = 2,
   parameter bit NV_PRESENT   = 1'b1,
   parameter bit HAS_ADDR_PIN = 1'b1,
   parameter int NV_LOAD_CYC  = `DGS_NV_LOAD_CYC,
   parameter int NV_WRITE_CYC = `DGS_NV_WRITE_CYC
) (
   // clock and power-on reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   // pins
   input  wire logic                   bor_detect,
   input  wire logic                   high_volt_cmd_pin,
   input  wire logic                   addr_pin_hi,
   input  wire logic                   addr_pin_lo,
   // neighbour registers
   input  wire logic [2*NUM_CH-1:0]    ref_source_sel,
   input  wire logic [NUM_CH-1:0]      cfg_lock,
   // register port
   input  wire logic                   reg_cmd_valid,
   input  wire logic                   reg_cmd_write,
   input  wire logic [`DGS_ADDR_W-1:0] reg_cmd_addr,
   input  wire logic [15:0]            reg_cmd_wdata,
   output logic                        reg_rsp_valid,
   output logic                        reg_rsp_error,
   output logic      [15:0]            reg_rsp_rdata,
   // status and configuration out
   output logic      [NUM_CH-1:0]      gain_sel_chx,
   output logic                        nv_access_busy,
   output logic      [6:0]             bus_target_addr
);

   localparam logic [1:0] CH_MASK = (NUM_CH == 2) ? 2'h3 : 2'h1;

   localparam dgs_state_type RESET_ST = '{
      phase:    st_load,
      cnt:      16'(NV_LOAD_CYC - 1),
      por_flag: 1'b1,
      nv_busy:  NV_PRESENT,
      default:  '0
   };

   dgs_state_type st;
   dgs_state_type next_st;
   logic          bor_edge;
   logic          nv_wr;
   logic [15:0]   nv_wdata;
   logic [15:0]   nv_rd;
   logic [3:0]    ref_sel_full;

   // ***********************************************
   // nonvolatile store
   // ***********************************************
   dgs_nv_mem #(
      .WIDTH (16),
      .DEPTH (1),
      .AW    (1),
      .INIT  (`DGS_NV_INIT)
   ) u_nv_mem (
      .ref_clk (ref_clk),
      .wr_en   (nv_wr),
      .wr_addr (1'b0),
      .wr_data (nv_wdata),
      .rd_addr (1'b0),
      .rd_data (nv_rd)
   );

   // ***********************************************
   // next state
   // ***********************************************
   always_comb begin
      next_st      = st;
      ref_sel_full = 4'(ref_source_sel);
      nv_wr        = 1'b0;
      nv_wdata     = dgs_stored_word(reg_cmd_wdata, CH_MASK);
      // pin synchronisers
      next_st.hv_s1    = high_volt_cmd_pin;
      next_st.hv_s2    = st.hv_s1;
      next_st.pin_s1   = {addr_pin_hi, addr_pin_lo};
      next_st.pin_s2   = st.pin_s1;
      next_st.bor_s1   = bor_detect;
      next_st.bor_s2   = st.bor_s1;
      next_st.bor_prev = st.bor_s2;
      bor_edge         = st.bor_s2 & ~st.bor_prev;
      next_st.rsp_valid = 1'b0;
      next_st.rsp_error = 1'b0;

      // memory sequencing
      case (st.phase)
         st_load: begin
            if (st.cnt == 16'h0000) begin
               next_st.phase    = st_idle;
               next_st.gain_vol = nv_rd[`DGS_GAIN_LSB +: 2] & CH_MASK;
            end else begin
               next_st.cnt = st.cnt - 16'h0001;
            end
         end
         st_nv_write: begin
            if (st.cnt == 16'h0000) begin
               next_st.phase = st_idle;
            end else begin
               next_st.cnt = st.cnt - 16'h0001;
            end
         end
         default: begin
            next_st.phase = st_idle;
         end
      endcase

      // register commands
      if (reg_cmd_valid) begin
         next_st.rsp_valid = 1'b1;
         next_st.rsp_rdata = 16'h0000;
         if (reg_cmd_addr == `DGS_GAIN_STATUS_OFS) begin
            if (reg_cmd_write) begin
               for (int ch = 0; ch < NUM_CH; ch++) begin
                  if (!cfg_lock[ch]) begin
                     next_st.gain_vol[ch] = reg_cmd_wdata[`DGS_GAIN_LSB + ch];
                  end
               end
            end else begin
               next_st.rsp_rdata = dgs_status_word(st.gain_vol, st.por_flag, st.nv_busy);
               next_st.por_flag  = 1'b0;
            end
         end else if (reg_cmd_addr == `DGS_STORED_OFS) begin
            if (st.nv_busy) begin
               next_st.rsp_error = 1'b1;
            end else if (reg_cmd_write) begin
               if (!NV_PRESENT || !st.hv_s2) begin
                  next_st.rsp_error = 1'b1;
               end else begin
                  nv_wr         = 1'b1;
                  next_st.phase = st_nv_write;
                  next_st.cnt   = 16'(NV_WRITE_CYC - 1);
               end
            end else begin
               next_st.rsp_rdata = dgs_stored_word(nv_rd, CH_MASK);
            end
         end else begin
            next_st.rsp_error = 1'b1;
         end
      end

      // brown-out: flag set wins over a same-cycle read clear
      if (bor_edge) begin
         next_st.por_flag = 1'b1;
         next_st.phase    = st_load;
         next_st.cnt      = 16'(NV_LOAD_CYC - 1);
      end

      next_st.nv_busy = NV_PRESENT && (next_st.phase != st_idle);

      for (int ch = 0; ch < 2; ch++) begin
         next_st.gain_eff[ch] = next_st.gain_vol[ch] && CH_MASK[ch]
                                && (ref_sel_full[2*ch +: 2] != `DGS_REF_SUPPLY);
      end

      if (HAS_ADDR_PIN) begin
         next_st.bus_addr = {nv_rd[`DGS_ADDR_MSB:`DGS_ADDR_PIN_LSB], st.pin_s2};
      end else begin
         next_st.bus_addr = nv_rd[`DGS_ADDR_MSB:0];
      end
   end

   // ***********************************************
   // state register
   // ***********************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st <= RESET_ST;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rsp_valid   = st.rsp_valid;
   assign reg_rsp_error   = st.rsp_error;
   assign reg_rsp_rdata   = st.rsp_rdata;
   assign gain_sel_chx    = st.gain_eff[NUM_CH-1:0];
   assign nv_access_busy  = st.nv_busy;
   assign bus_target_addr = st.bus_addr;

   // ***********************************************
   // checks
   // ***********************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   logic rd_gs;
   logic wr_gs;
   logic acc_nv;
   assign rd_gs  = reg_cmd_valid && !reg_cmd_write && (reg_cmd_addr == `DGS_GAIN_STATUS_OFS);
   assign wr_gs  = reg_cmd_valid && reg_cmd_write && (reg_cmd_addr == `DGS_GAIN_STATUS_OFS);
   assign acc_nv = reg_cmd_valid && (reg_cmd_addr == `DGS_STORED_OFS);

   property p_gain_write;
      wr_gs && !cfg_lock[0] && !bor_edge && st.phase != st_load
         |=> st.gain_vol[0] == $past(reg_cmd_wdata[`DGS_GAIN_LSB]);
   endproperty
   a_gain_write: assert property (p_gain_write) else $error("gain write lost");

   property p_unity_on_supply;
      ref_source_sel[1:0] == `DGS_REF_SUPPLY |=> !gain_sel_chx[0];
   endproperty
   a_unity_on_supply: assert property (p_unity_on_supply) else $error("gain not forced to unity");

   property p_por_after_reset;
      $rose(rst_n) |-> st.por_flag && st.phase == st_load;
   endproperty
   a_por_after_reset: assert property (p_por_after_reset) else $error("power-on flag not set");

   property p_bor_sets;
      bor_edge |=> st.por_flag ##0 nv_access_busy == NV_PRESENT;
   endproperty
   a_bor_sets: assert property (p_bor_sets) else $error("brown-out not flagged");

   property p_read_clears;
      rd_gs && !bor_edge |=> !st.por_flag;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read did not clear flag");

   property p_read_shows_flag;
      rd_gs |=> reg_rsp_valid && reg_rsp_rdata[`DGS_POR_BIT] == $past(st.por_flag);
   endproperty
   a_read_shows_flag: assert property (p_read_shows_flag) else $error("answer lost flag");

   property p_busy_tracks;
      nv_access_busy == (NV_PRESENT && st.phase != st_idle);
   endproperty
   a_busy_tracks: assert property (p_busy_tracks) else $error("busy flag wrong");

   property p_nv_refused;
      acc_nv && nv_access_busy |=> reg_rsp_error;
   endproperty
   a_nv_refused: assert property (p_nv_refused) else $error("nonvolatile access while busy");

   property p_zero_bits;
      reg_rsp_valid |-> reg_rsp_rdata[15:10] == 6'h00
                        && ($past(reg_cmd_addr) != `DGS_GAIN_STATUS_OFS || reg_rsp_rdata[5:0] == 6'h00)
                        && ($past(reg_cmd_addr) != `DGS_STORED_OFS || !reg_rsp_rdata[7]);
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("unimplemented bit set");

   property p_hv_needed;
      acc_nv && reg_cmd_write && !st.hv_s2 |=> reg_rsp_error && st.phase != st_nv_write;
   endproperty
   a_hv_needed: assert property (p_hv_needed) else $error("write without high voltage");

   property p_addr_pins;
      HAS_ADDR_PIN |=> bus_target_addr[1:0] == $past(st.pin_s2)
                       && bus_target_addr[6:2] == $past(nv_rd[6:2]);
   endproperty
   a_addr_pins: assert property (p_addr_pins) else $error("bus address mismatch");

endmodule // dgs_top

// [verification/dgs_host_model.sv]
`timescale 1ns/10ps
`include "dgs_regs.svh"

module dgs_host_model (
   // clock
   input  wire logic                   ref_clk,
   // command side
   output logic                        reg_cmd_valid,
   output logic                        reg_cmd_write,
   output logic [`DGS_ADDR_W-1:0]      reg_cmd_addr,
   output logic [15:0]                 reg_cmd_wdata,
   // answer side
   input  wire logic                   reg_rsp_valid,
   input  wire logic                   reg_rsp_error,
   input  wire logic [15:0]            reg_rsp_rdata,
   input  wire logic                   nv_access_busy
);
   logic        break_busy_rule = 1'h0;
   logic        timed_out = 1'h0;
   logic        got_valid;
   logic        got_err;
   logic [15:0] got_data;

   initial begin
      reg_cmd_valid = 1'h0;
      reg_cmd_write = 1'h0;
      reg_cmd_addr  = 5'h15;
      reg_cmd_wdata = 16'h5A5A;
   end

   // ***********************************************
   // one command, called at a falling edge
   // ***********************************************
   task automatic cmd(input logic w, input logic [`DGS_ADDR_W-1:0] a, input logic [15:0] d);
      int n;
      // one idle edge after the previous release keeps the strobe single-driven per time step
      @(negedge ref_clk);
      for (n = 0; n < 2000 && a == `DGS_STORED_OFS && !break_busy_rule && nv_access_busy !== 1'h0; n++) begin
         @(negedge ref_clk);
      end
      if (n >= 2000) begin
         timed_out = 1'h1;
      end
      reg_cmd_valid <= 1'h1;
      reg_cmd_write <= w;
      reg_cmd_addr  <= a;
      reg_cmd_wdata <= d;
      @(negedge ref_clk);
      got_valid = reg_rsp_valid;
      got_err   = reg_rsp_error;
      got_data  = reg_rsp_rdata;
      reg_cmd_valid <= 1'h0;
      reg_cmd_write <= ~w;
      reg_cmd_addr  <= ~a;
      reg_cmd_wdata <= ~d;
   endtask
endmodule // dgs_host_model

// [verification/tb_top.sv]
`timescale 1ns/10ps
`include "dgs_regs.svh"

module tb_top;
   logic        ref_clk = 1'h0;
   logic        rst_n = 1'h0;
   logic        bor_detect = 1'h0;
   logic        high_volt_cmd_pin = 1'h0;
   logic        addr_pin_hi = 1'h0;
   logic        addr_pin_lo = 1'h1;
   logic [3:0]  ref_source_sel = 4'hF;
   logic [1:0]  cfg_lock = 2'h0;
   logic        reg_cmd_valid;
   logic        reg_cmd_write;
   logic [4:0]  reg_cmd_addr;
   logic [15:0] reg_cmd_wdata;
   logic        reg_rsp_valid;
   logic        reg_rsp_error;
   logic [15:0] reg_rsp_rdata;
   logic [1:0]  gain_sel_chx;
   logic        nv_access_busy;
   logic [6:0]  bus_target_addr;
   logic        busy_v;
   logic        err_v;
   int          mismatches = 0;
   int          n_checks = 0;
   int          seed = 98848;
   int          i;
   logic [4:0]  a;
   logic [15:0] d;
   logic [15:0] nvd;
   logic [1:0]  vg = 2'h0;
   logic [1:0]  lk;
   logic [3:0]  rs;

   dgs_top #(.NV_LOAD_CYC(8), .NV_WRITE_CYC(16)) dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .bor_detect(bor_detect), .high_volt_cmd_pin(high_volt_cmd_pin),
      .addr_pin_hi(addr_pin_hi), .addr_pin_lo(addr_pin_lo), .ref_source_sel(ref_source_sel), .cfg_lock(cfg_lock),
      .reg_cmd_valid(reg_cmd_valid), .reg_cmd_write(reg_cmd_write), .reg_cmd_addr(reg_cmd_addr),
      .reg_cmd_wdata(reg_cmd_wdata), .reg_rsp_valid(reg_rsp_valid), .reg_rsp_error(reg_rsp_error),
      .reg_rsp_rdata(reg_rsp_rdata), .gain_sel_chx(gain_sel_chx), .nv_access_busy(nv_access_busy),
      .bus_target_addr(bus_target_addr));

   dgs_top #(.NV_PRESENT(1'h0), .NV_LOAD_CYC(8), .NV_WRITE_CYC(16)) dut_v (
      .ref_clk(ref_clk), .rst_n(rst_n), .bor_detect(bor_detect), .high_volt_cmd_pin(high_volt_cmd_pin),
      .addr_pin_hi(addr_pin_hi), .addr_pin_lo(addr_pin_lo), .ref_source_sel(ref_source_sel), .cfg_lock(cfg_lock),
      .reg_cmd_valid(reg_cmd_valid), .reg_cmd_write(reg_cmd_write), .reg_cmd_addr(reg_cmd_addr),
      .reg_cmd_wdata(reg_cmd_wdata), .reg_rsp_valid(), .reg_rsp_error(err_v), .reg_rsp_rdata(),
      .gain_sel_chx(), .nv_access_busy(busy_v), .bus_target_addr());

   dgs_host_model host_u (
      .ref_clk(ref_clk), .reg_cmd_valid(reg_cmd_valid), .reg_cmd_write(reg_cmd_write),
      .reg_cmd_addr(reg_cmd_addr), .reg_cmd_wdata(reg_cmd_wdata), .reg_rsp_valid(reg_rsp_valid),
      .reg_rsp_error(reg_rsp_error), .reg_rsp_rdata(reg_rsp_rdata), .nv_access_busy(nv_access_busy));

   always #5 ref_clk = ~ref_clk;

   // ***********************************************
   // helpers
   // ***********************************************
   function automatic logic [15:0] exp_st(input logic [1:0] g, input logic p, input logic b);
      return {6'h00, g, p, b, 6'h00};
   endfunction

   function automatic logic [1:0] exp_eff(input logic [1:0] g, input logic [3:0] r);
      return {g[1] & (r[3:2] != 2'h0), g[0] & (r[1:0] != 2'h0)};
   endfunction

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rsp(input logic e, input logic [15:0] x);
      check({14'h0000, host_u.got_valid, host_u.got_err}, {14'h0000, 1'h1, e});
      check(host_u.got_data, x);
   endtask

   task automatic wait_idle;
      int n;
      for (n = 0; n < 2000 && nv_access_busy !== 1'h0; n++) begin
         @(negedge ref_clk);
      end
      if (n >= 2000) begin
         mismatches++;
         stop_test();
      end
   endtask

   task automatic done(input string s);
      $display("test %s ended", s);
      if (host_u.timed_out) begin
         mismatches++;
         stop_test();
      end
   endtask

   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      repeat (3) @(negedge ref_clk);
      rst_n = 1'h1;
      host_u.cmd(1'h0, `DGS_GAIN_STATUS_OFS, 16'h0000);
      rsp(1'h0, exp_st(2'h0, 1'h1, 1'h1));
      check({15'h0000, busy_v}, 16'h0000);
      host_u.break_busy_rule = 1'h1;
      host_u.cmd(1'h0, `DGS_STORED_OFS, 16'h0000);
      rsp(1'h1, 16'h0000);
      host_u.break_busy_rule = 1'h0;
      wait_idle();
      host_u.cmd(1'h0, `DGS_GAIN_STATUS_OFS, 16'h0000);
      rsp(1'h0, exp_st(2'h0, 1'h0, 1'h0));
      done("reset");
      for (i = 0; i < 6; i++) begin
         a = 5'($random(seed));
         if (i == 0 || a == `DGS_GAIN_STATUS_OFS || a == `DGS_STORED_OFS) a = 5'h0B;
         host_u.cmd(1'(i), a, 16'($random(seed)));
         rsp(1'h1, 16'h0000);
      end
      done("unmapped");
      for (i = 0; i < 10; i++) begin
         d = 16'($random(seed));
         lk = 2'($random(seed));
         rs = 4'($random(seed));
         if (i == 0) begin
            d = 16'hFFFF;
            lk = 2'h0;
            rs = 4'h0;
         end
         cfg_lock = lk;
         ref_source_sel = rs;
         host_u.cmd(1'h1, `DGS_GAIN_STATUS_OFS, d);
         rsp(1'h0, 16'h0000);
         if (!lk[0]) vg[0] = d[8];
         if (!lk[1]) vg[1] = d[9];
         host_u.cmd(1'h0, `DGS_GAIN_STATUS_OFS, 16'h0000);
         rsp(1'h0, exp_st(vg, 1'h0, 1'h0));
         check({14'h0000, gain_sel_chx}, {14'h0000, exp_eff(vg, rs)});
      end
      done("gain");
      {addr_pin_hi, addr_pin_lo} = 2'($random(seed));
      nvd = 16'($random(seed)) | 16'hFC80;
      host_u.cmd(1'h1, `DGS_STORED_OFS, nvd);
      rsp(1'h1, 16'h0000);
      high_volt_cmd_pin = 1'h1;
      cfg_lock = 2'h3;
      repeat (3) @(negedge ref_clk);
      host_u.cmd(1'h1, `DGS_STORED_OFS, nvd);
      rsp(1'h0, 16'h0000);
      check({15'h0000, err_v}, 16'h0001);
      check({15'h0000, nv_access_busy}, 16'h0001);
      host_u.cmd(1'h0, `DGS_GAIN_STATUS_OFS, 16'h0000);
      rsp(1'h0, exp_st(vg, 1'h0, 1'h1));
      host_u.break_busy_rule = 1'h1;
      host_u.cmd(1'h1, `DGS_STORED_OFS, ~nvd);
      rsp(1'h1, 16'h0000);
      host_u.break_busy_rule = 1'h0;
      wait_idle();
      high_volt_cmd_pin = 1'h0;
      host_u.cmd(1'h0, `DGS_STORED_OFS, 16'h0000);
      rsp(1'h0, {6'h00, nvd[9:8], 1'h0, nvd[6:0]});
      check({9'h000, bus_target_addr}, {9'h000, nvd[6:2], addr_pin_hi, addr_pin_lo});
      {addr_pin_hi, addr_pin_lo} = ~{addr_pin_hi, addr_pin_lo};
      repeat (5) @(negedge ref_clk);
      check({9'h000, bus_target_addr}, {9'h000, nvd[6:2], addr_pin_hi, addr_pin_lo});
      done("stored");
      bor_detect = 1'h1;
      repeat (2) @(negedge ref_clk);
      bor_detect = 1'h0;
      repeat (3) @(negedge ref_clk);
      check({15'h0000, nv_access_busy}, 16'h0001);
      check({15'h0000, busy_v}, 16'h0000);
      wait_idle();
      vg = nvd[9:8];
      host_u.cmd(1'h0, `DGS_GAIN_STATUS_OFS, 16'h0000);
      rsp(1'h0, exp_st(vg, 1'h1, 1'h0));
      check({14'h0000, gain_sel_chx}, {14'h0000, exp_eff(vg, ref_source_sel)});
      host_u.cmd(1'h0, `DGS_GAIN_STATUS_OFS, 16'h0000);
      rsp(1'h0, exp_st(vg, 1'h0, 1'h0));
      done("brownout");
      stop_test();
   end
endmodule // tb_top
